// ---- shared/sscr_pkg.sv ----
package sscr_pkg;

    // Register index as numbered on the device; byte address is four times it
    localparam logic [7:0] STEP_CFG_INDEX = 8'h9E;
    localparam logic [31:0] STEP_CFG_ADDR = {22'h000000, STEP_CFG_INDEX, 2'h0};
    localparam logic [15:0] STEP_CFG_RESET = 16'h000E;
    // Writable bits: enable, gain, negative select, positive select
    localparam logic [15:0] STEP_CFG_WRITE_MASK = 16'hE01F;

    localparam int EN_POS = 15;
    localparam int GAIN_MSB = 14;
    localparam int GAIN_LSB = 13;
    localparam int RSVD_MSB = 12;
    localparam int RSVD_LSB = 5;
    localparam int NEG_POS = 4;
    localparam int POS_MSB = 3;
    localparam int POS_LSB = 0;

    localparam logic [1:0] GAIN_CODE_X1 = 2'h0;
    localparam logic [1:0] GAIN_CODE_X2 = 2'h1;
    localparam logic [2:0] GAIN_FACTOR_1 = 3'h1;
    localparam logic [2:0] GAIN_FACTOR_2 = 3'h2;
    localparam logic [2:0] GAIN_FACTOR_4 = 3'h4;

    localparam logic [3:0] POS_CODE_EXT_LAST = 4'h7;
    localparam logic [3:0] POS_CODE_TEMP = 4'h8;
    localparam logic [3:0] POS_CODE_SHORT = 4'h9;
    localparam logic [3:0] POS_CODE_TEST = 4'hA;
    localparam logic [3:0] POS_CODE_ANALOG_SUPPLY = 4'hE;
    localparam logic [3:0] POS_CODE_DIGITAL_SUPPLY = 4'hF;

    localparam logic [1:0] HTRANS_IDLE = 2'h0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic HRESP_OKAY = 1'b0;

    typedef enum logic [2:0] {
        POS_EXTERNAL = 3'h0,
        POS_TEMP_SENSOR = 3'h1,
        POS_GROUND_SHORT = 3'h2,
        POS_TEST_SOURCE = 3'h3,
        POS_OTHER_MONITOR = 3'h4,
        POS_ANALOG_SUPPLY_DIV = 3'h5,
        POS_DIGITAL_SUPPLY_DIV = 3'h6
    } sscr_pos_kind_type;

    typedef enum logic [1:0] {
        NEG_ANALOG_GROUND = 2'h0,
        NEG_EXTERNAL_SEVEN = 2'h1,
        NEG_AUTOMATIC = 2'h2
    } sscr_neg_route_type;

    typedef struct packed {
        logic stepEnable;
        logic [2:0] gainFactor;
        sscr_pos_kind_type posKind;
        logic [2:0] posChannel;
        sscr_neg_route_type negRoute;
    } sscr_route_type;

endpackage

// ---- src/sscr_input_decode.sv ----
module sscr_input_decode (
    input wire logic [15:0] stepConfig,
    output sscr_pkg::sscr_route_type route
);
    import sscr_pkg::*;

    function automatic logic [2:0] gainFactorOf(input logic [1:0] code);
        if (code == GAIN_CODE_X1) begin
            return GAIN_FACTOR_1;
        end else if (code == GAIN_CODE_X2) begin
            return GAIN_FACTOR_2;
        end
        return GAIN_FACTOR_4;
    endfunction

    function automatic sscr_pos_kind_type posKindOf(input logic [3:0] code);
        if (code <= POS_CODE_EXT_LAST) begin
            return POS_EXTERNAL;
        end else if (code == POS_CODE_TEMP) begin
            return POS_TEMP_SENSOR;
        end else if (code == POS_CODE_SHORT) begin
            return POS_GROUND_SHORT;
        end else if (code == POS_CODE_TEST) begin
            return POS_TEST_SOURCE;
        end else if (code == POS_CODE_ANALOG_SUPPLY) begin
            return POS_ANALOG_SUPPLY_DIV;
        end else if (code == POS_CODE_DIGITAL_SUPPLY) begin
            return POS_DIGITAL_SUPPLY_DIV;
        end
        return POS_OTHER_MONITOR;
    endfunction

    logic [3:0] posCode;
    logic autoNeg;

    assign posCode = stepConfig[POS_MSB:POS_LSB];
    // Every code with the top bit set is an internal source with its own negative
    assign autoNeg = posCode[3];

    always_comb begin
        route.stepEnable = stepConfig[EN_POS];
        route.gainFactor = gainFactorOf(stepConfig[GAIN_MSB:GAIN_LSB]);
        route.posKind = posKindOf(posCode);
        route.posChannel = autoNeg ? 3'h0 : posCode[2:0];
        if (autoNeg) begin
            route.negRoute = NEG_AUTOMATIC;
        end else if (stepConfig[NEG_POS]) begin
            route.negRoute = NEG_EXTERNAL_SEVEN;
        end else begin
            route.negRoute = NEG_ANALOG_GROUND;
        end
    end
endmodule

// ---- src/sscr_step_config.sv ----
module sscr_step_config (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic [15:0] stepConfig,
    output sscr_pkg::sscr_route_type stepRoute
);
    import sscr_pkg::*;

    logic [15:0] cfgQ;
    logic [15:0] cfgD;
    logic wrPendQ;
    logic rdHitD;
    logic addrTaken;
    logic addrHit;
    logic [31:0] hrdataQ;
    sscr_route_type routeD;
    sscr_route_type routeQ;

    // Zero-wait slave: every transfer completes in its first data-phase cycle
    assign hreadyout = 1'b1;
    assign hresp = HRESP_OKAY;
    assign addrTaken = hsel && htrans[1] && hready;
    assign addrHit = (haddr == STEP_CFG_ADDR);

    // Only whole-word writes to the mapped address land; others are dropped silently
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wrPendQ <= 1'b0;
        end else if (hready) begin
            wrPendQ <= addrTaken && hwrite && addrHit && (hsize == HSIZE_WORD);
        end
    end

    // Reserved bits are never stored, so they always read zero
    assign cfgD = hwdata[15:0] & STEP_CFG_WRITE_MASK;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfgQ <= STEP_CFG_RESET;
        end else if (wrPendQ) begin
            cfgQ <= cfgD;
        end
    end

    // Read data is latched in the address phase; forwarding covers a write just ahead
    assign rdHitD = addrTaken && !hwrite && addrHit;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hrdataQ <= 32'h00000000;
        end else if (rdHitD) begin
            hrdataQ <= {16'h0000, wrPendQ ? cfgD : cfgQ};
        end else if (addrTaken) begin
            hrdataQ <= 32'h00000000;
        end
    end

    assign hrdata = hrdataQ;
    assign stepConfig = cfgQ;

    sscr_input_decode u_decode (
        .stepConfig(cfgQ),
        .route(routeD)
    );

    // Registered so the analog mux sees no decode glitches
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            routeQ <= '{stepEnable: 1'b0, gainFactor: GAIN_FACTOR_1, posKind: POS_ANALOG_SUPPLY_DIV,
                        posChannel: 3'h0, negRoute: NEG_AUTOMATIC};
        end else begin
            routeQ <= routeD;
        end
    end

    assign stepRoute = routeQ;

    // Checks
    logic firstQ;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            firstQ <= 1'b1;
        end else begin
            firstQ <= 1'b0;
        end
    end

    default clocking cb @(posedge clk);
    endclocking

    default disable iff (!arst_n);

    sequence sWriteAddr;
        addrTaken && hwrite && addrHit && (hsize == HSIZE_WORD);
    endsequence

    sequence sReadAddr;
        addrTaken && !hwrite && addrHit;
    endsequence

    sequence sDataPhase;
        hready;
    endsequence

    sequence sNarrowWrite;
        addrTaken && hwrite && addrHit && (hsize != HSIZE_WORD);
    endsequence

    sequence sOtherAddr;
        addrTaken && !addrHit;
    endsequence

    sequence sWriteDone;
        sWriteAddr ##1 sDataPhase;
    endsequence

    a_reset_value: assert property (firstQ |-> cfgQ == STEP_CFG_RESET && !stepRoute.stepEnable)
        else $error("step register not at reset value after reset");

    a_reset_route: assert property (firstQ |-> stepRoute.posKind == POS_ANALOG_SUPPLY_DIV
                                            && stepRoute.gainFactor == GAIN_FACTOR_1)
        else $error("step route not at reset selection");

    a_write_lands: assert property (sWriteAddr ##1 sDataPhase
                                    |=> cfgQ == ($past(hwdata[15:0]) & STEP_CFG_WRITE_MASK))
        else $error("register write did not land masked");

    a_reserved_zero: assert property (cfgQ[RSVD_MSB:RSVD_LSB] == 8'h00 && hrdata[31:RSVD_LSB + 11] == 16'h0000
                                      && hrdata[RSVD_MSB:RSVD_LSB] == 8'h00)
        else $error("reserved bits read nonzero");

    a_read_back: assert property (sReadAddr ##0 !wrPendQ |=> hrdata == {16'h0000, $past(cfgQ)})
        else $error("read data differs from register");

    a_no_stray_write: assert property (!wrPendQ |=> cfgQ == $past(cfgQ))
        else $error("register changed without a write");

    a_enable_gates: assert property (##1 stepRoute.stepEnable == $past(cfgQ[EN_POS]))
        else $error("step enable does not follow bit 15");

    a_gain_map: assert property (##1 stepRoute.gainFactor ==
                                 ($past(cfgQ[GAIN_MSB:GAIN_LSB]) == GAIN_CODE_X1 ? GAIN_FACTOR_1 :
                                  $past(cfgQ[GAIN_MSB:GAIN_LSB]) == GAIN_CODE_X2 ? GAIN_FACTOR_2 :
                                  GAIN_FACTOR_4))
        else $error("gain factor wrong for gain code");

    a_neg_manual: assert property (!cfgQ[POS_MSB] |=> stepRoute.negRoute ==
                                   ($past(cfgQ[NEG_POS]) ? NEG_EXTERNAL_SEVEN : NEG_ANALOG_GROUND))
        else $error("negative input select not honoured");

    a_pos_external: assert property (cfgQ[POS_MSB:POS_LSB] <= POS_CODE_EXT_LAST
                                     |=> stepRoute.posKind == POS_EXTERNAL
                                         && stepRoute.posChannel == $past(cfgQ[2:0]))
        else $error("external positive input misrouted");

    a_internal_src: assert property (cfgQ[POS_MSB] |=> stepRoute.posChannel == 3'h0
                                     && stepRoute.negRoute == NEG_AUTOMATIC)
        else $error("internal source not on automatic negative");

    a_temp_source: assert property (cfgQ[POS_MSB:POS_LSB] == POS_CODE_TEMP
                                    |=> stepRoute.posKind == POS_TEMP_SENSOR)
        else $error("temperature sensor code misdecoded");

    a_short_source: assert property (cfgQ[POS_MSB:POS_LSB] == POS_CODE_SHORT
                                     |=> stepRoute.posKind == POS_GROUND_SHORT)
        else $error("ground short code misdecoded");

    a_test_source: assert property (cfgQ[POS_MSB:POS_LSB] == POS_CODE_TEST
                                    |=> stepRoute.posKind == POS_TEST_SOURCE)
        else $error("test source code misdecoded");

    a_supply_div: assert property ((cfgQ[POS_MSB:POS_LSB] == POS_CODE_ANALOG_SUPPLY
                                    |=> stepRoute.posKind == POS_ANALOG_SUPPLY_DIV)
                                   and (cfgQ[POS_MSB:POS_LSB] == POS_CODE_DIGITAL_SUPPLY
                                    |=> stepRoute.posKind == POS_DIGITAL_SUPPLY_DIV))
        else $error("supply monitor code misdecoded");

    a_neg_auto_ignored: assert property (cfgQ[POS_MSB] [*2] |-> stepRoute.negRoute == NEG_AUTOMATIC
                                         && stepRoute.posKind != POS_EXTERNAL)
        else $error("negative select not ignored for internal source");

    a_always_okay: assert property (hreadyout && hresp == HRESP_OKAY)
        else $error("bus response not ready and okay");

    a_narrow_ignored: assert property (sNarrowWrite |=> ##1 cfgQ == $past(cfgQ))
        else $error("narrow write changed the register");

    a_other_write_ignored: assert property (sOtherAddr ##0 hwrite |=> ##1 cfgQ == $past(cfgQ))
        else $error("write to another address changed the register");

    a_other_read_zero: assert property (sOtherAddr |=> hrdata == 32'h00000000)
        else $error("unmapped address did not read zero");

    a_read_forward: assert property (sReadAddr ##0 wrPendQ
        |=> hrdata == {16'h0000, $past(hwdata[15:0]) & STEP_CFG_WRITE_MASK})
        else $error("read after write missed the new value");

    a_read_data_holds: assert property (!addrTaken |=> $stable(hrdata))
        else $error("read data moved without a transfer");

    a_route_steady: assert property ($stable(cfgQ) |=> $stable(stepRoute))
        else $error("route changed while the register held");

    a_gain_top_codes: assert property (cfgQ[GAIN_MSB] |=> stepRoute.gainFactor == GAIN_FACTOR_4)
        else $error("gain codes 10 and 11 not gain four");

    a_gain_code_two: assert property (cfgQ[GAIN_MSB:GAIN_LSB] == GAIN_CODE_X2 |=> stepRoute.gainFactor == GAIN_FACTOR_2)
        else $error("gain code 01 not gain two");

    a_gain_code_one: assert property (cfgQ[GAIN_MSB:GAIN_LSB] == GAIN_CODE_X1 |=> stepRoute.gainFactor == GAIN_FACTOR_1)
        else $error("gain code 00 not gain one");

    a_seven_pair: assert property (cfgQ[POS_MSB:POS_LSB] == POS_CODE_EXT_LAST && cfgQ[NEG_POS]
        |=> stepRoute.posChannel == 3'h7 && stepRoute.negRoute == NEG_EXTERNAL_SEVEN)
        else $error("input seven pair misrouted");

    a_ext_ground: assert property (cfgQ[POS_MSB:POS_LSB] == 4'h0 && !cfgQ[NEG_POS]
        |=> stepRoute.posChannel == 3'h0 && stepRoute.negRoute == NEG_ANALOG_GROUND)
        else $error("input zero against ground misrouted");

    a_auto_any_neg: assert property (cfgQ[POS_MSB] && cfgQ[NEG_POS] |=> stepRoute.negRoute == NEG_AUTOMATIC)
        else $error("negative select honoured for automatic source");

    a_disable_step: assert property (!cfgQ[EN_POS] |=> !stepRoute.stepEnable)
        else $error("step enabled while bit 15 clear");

    a_enable_step: assert property (cfgQ[EN_POS] |=> stepRoute.stepEnable)
        else $error("step disabled while bit 15 set");

    a_write_route: assert property (sWriteDone
        |=> ##1 stepRoute.stepEnable == $past(hwdata[EN_POS], 2))
        else $error("written enable did not reach the route");

    a_reset_outputs: assert property (firstQ |-> hrdata == 32'h00000000
        && stepRoute.negRoute == NEG_AUTOMATIC && stepRoute.posChannel == 3'h0)
        else $error("outputs not at reset state after reset");

    a_okay_each: assert property (addrTaken |=> hreadyout && hresp == HRESP_OKAY)
        else $error("transfer not answered ready and okay");

    a_analog_div: assert property (cfgQ[POS_MSB:POS_LSB] == POS_CODE_ANALOG_SUPPLY
        |=> stepRoute.negRoute == NEG_AUTOMATIC && stepRoute.posChannel == 3'h0)
        else $error("analog supply monitor not automatic");

    a_digital_div: assert property (cfgQ[POS_MSB:POS_LSB] == POS_CODE_DIGITAL_SUPPLY
        |=> stepRoute.negRoute == NEG_AUTOMATIC && stepRoute.posChannel == 3'h0)
        else $error("digital supply monitor not automatic");

    a_write_neg: assert property (sWriteDone |=> stepConfig[NEG_POS] == $past(hwdata[NEG_POS]))
        else $error("written negative select not stored");

    a_write_pos: assert property (sWriteDone
        |=> stepConfig[POS_MSB:POS_LSB] == $past(hwdata[POS_MSB:POS_LSB]))
        else $error("written positive select not stored");

    a_write_gain: assert property (sWriteDone
        |=> stepConfig[GAIN_MSB:GAIN_LSB] == $past(hwdata[GAIN_MSB:GAIN_LSB]))
        else $error("written gain code not stored");

    a_pend_from_addr: assert property (wrPendQ |-> $past(addrTaken && hwrite && addrHit))
        else $error("write pending without a mapped write");

endmodule

// ---- verification/sscr_step_config_tb.sv ----
module sscr_step_config_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import sscr_pkg::*;

    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h00000000;
    logic [31:0] hwdata = 32'h00000000;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [15:0] stepConfig;
    sscr_route_type stepRoute;
    integer badCount = 0;
    integer testsRun = 0;
    integer cycleCount = 0;
    integer seed = 23952;
    integer modelCfg = 32'h0000000E;

    sscr_step_config uut (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .stepConfig(stepConfig), .stepRoute(stepRoute));

    always #2.5 clk = ~clk;

    task automatic finish_test;
        $display("Comparisons %0d mismatches %0d", testsRun, badCount);
        if (badCount == 0 && testsRun > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Short ceiling: the whole run is some seventy zero-wait transfers
    always @(posedge clk) begin
        cycleCount <= cycleCount + 1;
        if (cycleCount == 5000) begin
            badCount++;
            finish_test;
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            badCount++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Bench's own decode of a configuration word into the expected routing
    function automatic sscr_route_type route_exp(input integer v);
        sscr_route_type r;
        r.stepEnable = v[15];
        r.gainFactor = (v[14:13] == 2'h0) ? 3'h1 : (v[14:13] == 2'h1) ? 3'h2 : 3'h4;
        case (v[3:0])
            4'h8: r.posKind = POS_TEMP_SENSOR;
            4'h9: r.posKind = POS_GROUND_SHORT;
            4'hA: r.posKind = POS_TEST_SOURCE;
            4'hE: r.posKind = POS_ANALOG_SUPPLY_DIV;
            4'hF: r.posKind = POS_DIGITAL_SUPPLY_DIV;
            default: r.posKind = v[3] ? POS_OTHER_MONITOR : POS_EXTERNAL;
        endcase
        r.posChannel = v[3] ? 3'h0 : v[2:0];
        r.negRoute = v[3] ? NEG_AUTOMATIC : (v[4] ? NEG_EXTERNAL_SEVEN : NEG_ANALOG_GROUND);
        return r;
    endfunction

    task automatic bus_write(input logic [31:0] addr, input logic [31:0] data, input logic [2:0] size);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= 1'b1;
        haddr <= addr;
        hsize <= size;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= HTRANS_IDLE;
        hsel <= 1'b0;
        hwdata <= data;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        if (addr == STEP_CFG_ADDR && size == HSIZE_WORD)
            modelCfg = data & 32'h0000E01F;
    endtask

    task automatic bus_read(input logic [31:0] addr);
        logic [31:0] exp;
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= 1'b0;
        haddr <= addr;
        hsize <= HSIZE_WORD;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= HTRANS_IDLE;
        hsel <= 1'b0;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        exp = (addr == STEP_CFG_ADDR) ? modelCfg : 32'h00000000;
        check("hrdata", hrdata, exp);
        check("hresp", {31'h0, hresp}, {31'h0, HRESP_OKAY});
    endtask

    task automatic check_outputs;
        repeat (2) @(posedge clk);
        #1;
        check("stepConfig", {16'h0, stepConfig}, modelCfg);
        check("stepRoute", {20'h0, stepRoute}, {20'h0, route_exp(modelCfg)});
    endtask

    // Read issued in the write's data phase must see the new value
    task automatic write_then_read(input logic [31:0] data);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= 1'b1;
        haddr <= STEP_CFG_ADDR;
        hsize <= HSIZE_WORD;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hwrite <= 1'b0;
        hwdata <= data;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        modelCfg = data & 32'h0000E01F;
        htrans <= HTRANS_IDLE;
        hsel <= 1'b0;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        check("forwardRead", hrdata, modelCfg);
    endtask

    initial begin
        logic [31:0] data;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        check_outputs;
        check("resetValue", {16'h0, stepConfig}, 32'h0000000E);
        bus_read(STEP_CFG_ADDR);
        // Every positive code twice, once with each negative select, gain codes cycling
        for (int i = 0; i < 32; i++) begin
            data = $random(seed);
            data[3:0] = i[3:0];
            data[4] = i[4];
            data[14:13] = i[1:0];
            data[15] = i[2];
            bus_write(STEP_CFG_ADDR, data, HSIZE_WORD);
            bus_read(STEP_CFG_ADDR);
            check_outputs;
        end
        write_then_read($random(seed));
        check_outputs;
        // Refused traffic must leave the register alone
        bus_write(STEP_CFG_ADDR + 32'h4, $random(seed), HSIZE_WORD);
        bus_write(STEP_CFG_ADDR, $random(seed), 3'h0);
        bus_read(STEP_CFG_ADDR + 32'h4);
        bus_read(STEP_CFG_ADDR);
        check_outputs;
        bus_write(STEP_CFG_ADDR, 32'hFFFFFFFF, HSIZE_WORD);
        check_outputs;
        @(posedge clk);
        arst_n <= 1'b0;
        modelCfg = 32'h0000000E;
        check_outputs;
        @(posedge clk);
        arst_n <= 1'b1;
        check_outputs;
        bus_read(STEP_CFG_ADDR);
        finish_test;
    end
endmodule
